// file: rtl/dsr_pkg.sv
// Purpose: Constants for the debug status register block
// Assumes: 32-bit word access on the debug access port
// Notes:   Handler state and fault status offsets are local choices
package dsr_pkg;
    localparam logic [31:0] DSR_ADDR_HALT_CTRL    = 32'he000edf0;
    localparam logic [31:0] DSR_ADDR_CORE_SEL     = 32'he000edf4;
    localparam logic [31:0] DSR_ADDR_CORE_DATA    = 32'he000edf8;
    localparam logic [31:0] DSR_ADDR_EXC_MON      = 32'he000edfc;
    localparam logic [31:0] DSR_ADDR_RSVD_LO      = 32'he000ee00;
    localparam logic [31:0] DSR_ADDR_RSVD_HI      = 32'he000eeff;
    localparam logic [31:0] DSR_ADDR_HANDLER      = 32'he000ed24;
    localparam logic [31:0] DSR_ADDR_FAULT        = 32'he000ed30;
    localparam int          DSR_WIDTH             = 32;
    localparam int          DSR_SVC_PEND_BIT      = 15;
    localparam int          DSR_FLT_EXTERNAL      = 4;
    localparam int          DSR_FLT_VECTOR        = 3;
    localparam int          DSR_FLT_WATCH         = 2;
    localparam int          DSR_FLT_BREAK         = 1;
    localparam int          DSR_FLT_HALTED        = 0;
    localparam int          DSR_FLT_BITS          = 5;
    localparam logic [31:0] DSR_RESET_WORD        = 32'h0000_0000;
    localparam logic [4:0]  DSR_FLT_RESET         = 5'h00;
    localparam logic [31:0] DSR_HANDLER_MASK      = 32'h0000_8000;
    localparam logic [31:0] DSR_FAULT_MASK        = 32'h0000_001f;
endpackage

// file: rtl/dsr_sticky_bit.sv
// Purpose: One sticky flag set by hardware, cleared by write-one
// Assumes: Set and clear come from the same clock domain
// Notes:   Set wins over clear in the same cycle
`timescale 1ns/1ns
module dsr_sticky_bit (
    // Clock and power-on reset
    input  wire logic mclk_i,
    input  wire logic por_i,
    // Control
    input  wire logic set_i,
    input  wire logic clr_i,
    // State
    output logic      flag_o
);
    // Sticky flag; an event in the clearing cycle is kept
    always_ff @(posedge mclk_i) begin
        if (por_i) begin
            flag_o <= 1'b0;
        end else if (set_i) begin
            flag_o <= 1'b1;
        end else if (clr_i) begin
            flag_o <= 1'b0;
        end
    end
endmodule // dsr_sticky_bit

// file: rtl/dsr_pend_bit.sv
// Purpose: Exception pending flag with direct software write
// Assumes: Occur and activate pulses are synchronous to mclk_i
// Notes:   Hardware events take priority over a software write
`timescale 1ns/1ns
module dsr_pend_bit (
    // Clock and reset
    input  wire logic mclk_i,
    input  wire logic rst_i,
    // Control
    input  wire logic occur_i,
    input  wire logic activate_i,
    input  wire logic wr_i,
    input  wire logic wdata_i,
    // State
    output logic      pend_o
);
    // Occur sets, activate clears, otherwise software writes the value
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pend_o <= 1'b0;
        end else if (occur_i) begin
            pend_o <= 1'b1;
        end else if (activate_i) begin
            pend_o <= 1'b0;
        end else if (wr_i) begin
            pend_o <= wdata_i;
        end
    end
endmodule // dsr_pend_bit

// file: rtl/dsr_debug_regs.sv
// Purpose: Debug control block register file with fault status and handler state
// Assumes: Debug access port issues single-cycle word accesses on mclk_i
// Notes:   Core-facing event inputs are synchronous to mclk_i
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
module dsr_debug_regs
    import dsr_pkg::*;
(
    // Clock and resets
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    input  wire logic        por_i,
    // Debug access port
    input  wire logic        dap_sel_i,
    input  wire logic        dap_wr_i,
    input  wire logic [31:0] dap_addr_i,
    input  wire logic [31:0] dap_wdata_i,
    output logic      [31:0] dap_rdata_o,
    output logic             dap_ack_o,
    output logic             dap_err_o,
    // Debug events from the core
    input  wire logic        external_halt_request_input_i,
    input  wire logic        vector_catch_evt_i,
    input  wire logic        watchpoint_evt_i,
    input  wire logic        breakpoint_evt_i,
    input  wire logic        halt_request_evt_i,
    input  wire logic        step_done_i,
    // Supervisor call exception status
    input  wire logic        svc_occur_i,
    input  wire logic        svc_active_i,
    // Register contents toward the core
    output logic      [31:0] halt_control_status_o,
    output logic      [31:0] core_reg_selector_o,
    output logic      [31:0] core_reg_data_o,
    output logic      [31:0] exception_monitor_control_o,
    output logic             supervisor_call_pending_flag_o,
    output logic       [4:0] debug_fault_status_o,
    output logic             reenter_halt_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    // Access timing as the debugger sees it:
    //   edge 0: select, direction, address and write data are taken; a write lands
    //   edge 1: acknowledge, refusal flag and read data stand for one cycle
    // There is no stall, so a new access may be taken at every edge

    logic                    hit_halt;
    logic                    hit_sel;
    logic                    hit_data;
    logic                    hit_mon;
    logic                    hit_hand;
    logic                    hit_flt;
    logic                    hit_rsvd;
    logic                    wr_en;
    logic                    rd_en;
    logic [DSR_WIDTH-1:0]    halt_reg;
    logic [DSR_WIDTH-1:0]    sel_reg;
    logic [DSR_WIDTH-1:0]    data_reg;
    logic [DSR_WIDTH-1:0]    mon_reg;
    logic [DSR_FLT_BITS-1:0] flt_set;
    logic [DSR_FLT_BITS-1:0] flt_clr;
    logic [DSR_FLT_BITS-1:0] flt_q;
    logic                    svc_pend;
    logic [DSR_WIDTH-1:0]    rdata_next;
    logic                    hit_map;
    logic                    err_next;
    logic                    halt_src;
    logic                    wr_halt;
    logic                    wr_sel;
    logic                    wr_data;
    logic                    wr_mon;
    logic                    wr_hand;
    logic                    wr_flt;

    // Word decode of the fixed map; the debug port is the only access path
    assign hit_halt = (dap_addr_i == DSR_ADDR_HALT_CTRL);
    assign hit_sel  = (dap_addr_i == DSR_ADDR_CORE_SEL);
    assign hit_data = (dap_addr_i == DSR_ADDR_CORE_DATA);
    assign hit_mon  = (dap_addr_i == DSR_ADDR_EXC_MON);
    assign hit_hand = (dap_addr_i == DSR_ADDR_HANDLER);
    assign hit_flt  = (dap_addr_i == DSR_ADDR_FAULT);
    // Reserved extension window decodes to nothing and answers with error
    // Later extension registers must be decoded here ahead of the refusal
    assign hit_rsvd = (dap_addr_i >= DSR_ADDR_RSVD_LO) && (dap_addr_i <= DSR_ADDR_RSVD_HI);
    assign wr_en    = dap_sel_i && dap_wr_i;
    assign rd_en    = dap_sel_i && !dap_wr_i;

    // Any defined register; the reserved window never overlaps the map
    assign hit_map  = hit_halt || hit_sel || hit_data || hit_mon || hit_hand || hit_flt;

    // Refusal: outside the map, inside the reserved window, or a selector read
    // A refused write changes nothing, since no write strobe below fires for it
    assign err_next = dap_sel_i && (hit_rsvd || (rd_en && hit_sel) || !hit_map);

    ////////////////////////////////////////////////////////////////////////////
    // Write strobes

    // One strobe per register; each access is a full word, no byte lanes exist
    assign wr_halt  = wr_en && hit_halt;
    assign wr_sel   = wr_en && hit_sel;
    assign wr_data  = wr_en && hit_data;
    assign wr_mon   = wr_en && hit_mon;
    assign wr_hand  = wr_en && hit_hand;
    assign wr_flt   = wr_en && hit_flt;

    ////////////////////////////////////////////////////////////////////////////
    // Debug control block storage

    // Full-width storage; bit meanings are owned by the core side
    // No key field is checked, so every write to these four registers lands as sent
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            halt_reg <= DSR_RESET_WORD;
        end else if (wr_halt) begin
            halt_reg <= dap_wdata_i;
        end
    end

    // Selector is write-only; it is never returned on reads
    // A read of it is refused at the answer stage instead
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            sel_reg <= DSR_RESET_WORD;
        end else if (wr_sel) begin
            sel_reg <= dap_wdata_i;
        end
    end

    // Core data register
    // Holds the word moved to or from the core register named by the selector
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            data_reg <= DSR_RESET_WORD;
        end else if (wr_data) begin
            data_reg <= dap_wdata_i;
        end
    end

    // Exception and monitor control register
    // Stored whole; the core decodes its enables
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            mon_reg <= DSR_RESET_WORD;
        end else if (wr_mon) begin
            mon_reg <= dap_wdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fault status

    // Each defined bit is a sticky cell: an event sets it, a write of one clears it
    // Set wins over clear in one cycle, so an event is never lost to a debugger
    // that clears the register just as the event arrives
    // Local reset is deliberately not wired here; only power-on reset clears them

    // A halt request and a completed step share the halted bit
    assign halt_src = halt_request_evt_i || step_done_i;

    // Event sources per bit; a completed step also reports as halted
    always_comb begin
        flt_set                   = '0;
        flt_set[DSR_FLT_EXTERNAL] = external_halt_request_input_i;
        flt_set[DSR_FLT_VECTOR]   = vector_catch_evt_i;
        flt_set[DSR_FLT_WATCH]    = watchpoint_evt_i;
        flt_set[DSR_FLT_BREAK]    = breakpoint_evt_i;
        flt_set[DSR_FLT_HALTED]   = halt_src;
    end

    // Write-one-to-clear mask, reserved bits dropped
    assign flt_clr = wr_flt ? dap_wdata_i[DSR_FLT_BITS-1:0] : DSR_FLT_RESET;

    // One sticky cell per defined bit; of the two resets, only power-on reset clears them
    // Bits 31:5 have no cell, so they read zero and ignore writes
    genvar gi;
    generate
        for (gi = 0; gi < DSR_FLT_BITS; gi++) begin : g_flt
            dsr_sticky_bit u_bit (
                .mclk_i (mclk_i),
                .por_i  (por_i),
                .set_i  (flt_set[gi]),
                .clr_i  (flt_clr[gi]),
                .flag_o (flt_q[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Handler state

    // Supervisor call pending, writable by software, moved by the exception
    // An occurring exception outranks activation, and both outrank a write,
    // so a debugger write cannot hide an exception that arrives with it
    dsr_pend_bit u_svc (
        .mclk_i     (mclk_i),
        .rst_i      (srst_i),
        .occur_i    (svc_occur_i),
        .activate_i (svc_active_i),
        .wr_i       (wr_hand),
        .wdata_i    (dap_wdata_i[DSR_SVC_PEND_BIT]),
        .pend_o     (svc_pend)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    // Read mux; selector and reserved space read as zero
    // Only bit 15 of handler state and bits 4:0 of fault status exist
    always_comb begin
        rdata_next = DSR_RESET_WORD;
        if (hit_halt) begin
            rdata_next = halt_reg;
        end else if (hit_data) begin
            rdata_next = data_reg;
        end else if (hit_mon) begin
            rdata_next = mon_reg;
        end else if (hit_hand) begin
            rdata_next[DSR_SVC_PEND_BIT] = svc_pend;
        end else if (hit_flt) begin
            rdata_next[DSR_FLT_BITS-1:0] = flt_q;
        end
    end

    // Read data stands for one cycle with the acknowledge, zero otherwise
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            dap_rdata_o <= DSR_RESET_WORD;
        end else begin
            dap_rdata_o <= rd_en ? rdata_next : DSR_RESET_WORD;
        end
    end

    // Every access is answered exactly one cycle later; there is no stall
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            dap_ack_o <= 1'b0;
        end else begin
            dap_ack_o <= dap_sel_i;
        end
    end

    // Unmapped, reserved, or a read of the write-only selector
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            dap_err_o <= 1'b0;
        end else begin
            dap_err_o <= err_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs toward the core

    // Registered copies so every output leaves a flip-flop
    // The core sees a write one cycle after it lands, in the same cycle as the earliest debugger read-back
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            halt_control_status_o <= DSR_RESET_WORD;
        end else begin
            halt_control_status_o <= halt_reg;
        end
    end

    // Selector copy toward the core
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            core_reg_selector_o <= DSR_RESET_WORD;
        end else begin
            core_reg_selector_o <= sel_reg;
        end
    end

    // Core data copy toward the core
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            core_reg_data_o <= DSR_RESET_WORD;
        end else begin
            core_reg_data_o <= data_reg;
        end
    end

    // Exception and monitor control copy toward the core
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            exception_monitor_control_o <= DSR_RESET_WORD;
        end else begin
            exception_monitor_control_o <= mon_reg;
        end
    end

    // Pending flag copy; local reset clears it together with its source
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            supervisor_call_pending_flag_o <= 1'b0;
        end else begin
            supervisor_call_pending_flag_o <= svc_pend;
        end
    end

    // Fault status copy follows power-on reset only, like its source
    // A debugger read and this copy show a new event in the same cycle
    always_ff @(posedge mclk_i) begin
        if (por_i) begin
            debug_fault_status_o <= DSR_FLT_RESET;
        end else begin
            debug_fault_status_o <= flt_q;
        end
    end

    // Step completion asks the core to halt again, one cycle later
    // The request lasts one cycle; the core keeps its own halted state
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            reenter_halt_o <= 1'b0;
        end else begin
            reenter_halt_o <= step_done_i;
        end
    end

endmodule // dsr_debug_regs

// file: bench/dsr_debug_regs_monitor.sv
// Purpose: Port checker for the debug status register block
// Assumes: One clock, synchronous resets
// Notes:   Fault checks ignore srst_i, which must leave those bits alone
`timescale 1ns/1ns
module dsr_debug_regs_monitor (
    // Clock and resets
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    input  wire logic        por_i,
    // Access port
    input  wire logic        dap_sel_i,
    input  wire logic [31:0] dap_addr_i,
    input  wire logic [31:0] dap_rdata_o,
    input  wire logic        dap_ack_o,
    input  wire logic        dap_err_o,
    // Events and state
    input  wire logic        external_halt_request_input_i,
    input  wire logic        vector_catch_evt_i,
    input  wire logic        watchpoint_evt_i,
    input  wire logic        breakpoint_evt_i,
    input  wire logic        halt_request_evt_i,
    input  wire logic        step_done_i,
    input  wire logic        svc_occur_i,
    input  wire logic        supervisor_call_pending_flag_o,
    input  wire logic  [4:0] debug_fault_status_o,
    input  wire logic        reenter_halt_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    // Access into the reserved window
    sequence s_rsvd_req;
        dap_sel_i && dap_addr_i >= 32'he000ee00 && dap_addr_i <= 32'he000eeff;
    endsequence
    // Event pulse shows on the fault port two edges later; only power-on reset may stop it
    property p_flt(ev, int b);
        @(posedge mclk_i) disable iff (por_i) ev |-> ##2 debug_fault_status_o[b];
    endproperty
    ////////////////////////////////////////////////////////////////////////////
    a_ack_follows_sel: assert property (dap_sel_i |=> dap_ack_o) else $error("no ack after access");
    a_ack_only_sel: assert property (!dap_sel_i |=> !dap_ack_o) else $error("ack without access");
    a_rsvd_refused: assert property (s_rsvd_req |=> dap_ack_o && dap_err_o && dap_rdata_o == 32'h0)
        else $error("reserved access not refused");
    a_ext_flag_set: assert property (p_flt(external_halt_request_input_i, 4)) else $error("bit 4 not set");
    a_vec_flag_set: assert property (p_flt(vector_catch_evt_i, 3)) else $error("bit 3 not set");
    a_watch_flag_set: assert property (p_flt(watchpoint_evt_i, 2)) else $error("bit 2 not set");
    a_brk_flag_set: assert property (p_flt(breakpoint_evt_i, 1)) else $error("bit 1 not set");
    a_halt_flag_set: assert property (p_flt(halt_request_evt_i || step_done_i, 0))
        else $error("bit 0 not set");
    a_step_reenter: assert property (step_done_i |=> reenter_halt_o) else $error("no re-entry after step");
    a_svc_pend_set: assert property (svc_occur_i |-> ##[1:2] supervisor_call_pending_flag_o)
        else $error("pending not set");
    a_por_clears_flt: assert property (disable iff (1'b0) por_i [*2] |=> debug_fault_status_o == 5'h00)
        else $error("fault bits survive power-on reset");
endmodule // dsr_debug_regs_monitor

bind dsr_debug_regs dsr_debug_regs_monitor u_dsr_debug_regs_monitor (.mclk_i, .srst_i, .por_i, .dap_sel_i,
    .dap_addr_i, .dap_rdata_o, .dap_ack_o, .dap_err_o, .external_halt_request_input_i, .vector_catch_evt_i,
    .watchpoint_evt_i, .breakpoint_evt_i, .halt_request_evt_i, .step_done_i, .svc_occur_i,
    .supervisor_call_pending_flag_o, .debug_fault_status_o, .reenter_halt_o);

// file: bench/dsr_dbg_model.sv
// Purpose: External debugger issuing word accesses on the access port
// Assumes: One access per call, answer sampled one edge after it is taken
// Notes:   Released lines carry inverted values so stale data never matches
`timescale 1ns/1ns
module dsr_dbg_model (
    // Clock
    input  wire logic        mclk_i,
    // Access port, master side
    output logic             dap_sel_o,
    output logic             dap_wr_o,
    output logic      [31:0] dap_addr_o,
    output logic      [31:0] dap_wdata_o,
    input  wire logic [31:0] dap_rdata_i,
    input  wire logic        dap_ack_i,
    input  wire logic        dap_err_i
);
    // Idle bus at time zero
    initial begin
        dap_sel_o = 1'b0;
        dap_wr_o = 1'b0;
        dap_addr_o = 32'h0;
        dap_wdata_o = 32'h0;
    end
    // All register traffic goes through here, one word access per call
    task automatic access(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                          output logic [31:0] rd, output logic er, output logic ok);
        @(posedge mclk_i);
        #1;
        dap_sel_o = 1'b1;
        dap_wr_o = wr;
        dap_addr_o = a;
        dap_wdata_o = wd;
        @(posedge mclk_i);
        #1;
        dap_sel_o = 1'b0;
        dap_addr_o = ~dap_addr_o;
        dap_wdata_o = ~dap_wdata_o;
        ok = 1'b0;
        rd = 32'h0;
        er = 1'b0;
        for (int n = 0; n < 4 && !ok; n++) begin
            @(posedge mclk_i);
            if (dap_ack_i === 1'b1) begin
                ok = 1'b1;
                rd = dap_rdata_i;
                er = dap_err_i;
            end
        end
    endtask
endmodule // dsr_dbg_model

// file: bench/tb_top.sv
// Purpose: Self-checking bench for the debug status register block
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Event vector: [5] step, [4:0] fault causes, [6] svc occur, [7] svc active
`timescale 1ns/1ns
module tb_top;
    import dsr_pkg::*;
    logic        mclk_i, srst_i = 1'b1, por_i = 1'b1, dap_sel_i, dap_wr_i, dap_ack_o, dap_err_o;
    logic [31:0] dap_addr_i, dap_wdata_i, dap_rdata_o, hcs, crs, crd, emc;
    logic  [7:0] evt = 8'h00;
    logic  [4:0] flt;
    logic        pend, reenter;
    int          n_mismatch = 0, comparisons = 0;
    logic [31:0] map [5] = '{DSR_ADDR_HALT_CTRL, DSR_ADDR_CORE_DATA, DSR_ADDR_EXC_MON,
                             DSR_ADDR_HANDLER, DSR_ADDR_FAULT};
    ////////////////////////////////////////////////////////////////////////////
    // Clock, 100 ns period
    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end
    dsr_dbg_model u_dsr_dbg_model (.mclk_i, .dap_sel_o(dap_sel_i), .dap_wr_o(dap_wr_i), .dap_addr_o(dap_addr_i),
        .dap_wdata_o(dap_wdata_i), .dap_rdata_i(dap_rdata_o), .dap_ack_i(dap_ack_o), .dap_err_i(dap_err_o));
    dsr_debug_regs u_dsr_debug_regs (.mclk_i, .srst_i, .por_i, .dap_sel_i, .dap_wr_i, .dap_addr_i, .dap_wdata_i,
        .dap_rdata_o, .dap_ack_o, .dap_err_o, .external_halt_request_input_i(evt[4]), .vector_catch_evt_i(evt[3]),
        .watchpoint_evt_i(evt[2]), .breakpoint_evt_i(evt[1]), .halt_request_evt_i(evt[0]), .step_done_i(evt[5]),
        .svc_occur_i(evt[6]), .svc_active_i(evt[7]), .halt_control_status_o(hcs), .core_reg_selector_o(crs),
        .core_reg_data_o(crd), .exception_monitor_control_o(emc), .supervisor_call_pending_flag_o(pend),
        .debug_fault_status_o(flt), .reenter_halt_o(reenter));
    ////////////////////////////////////////////////////////////////////////////
    // Compare, close, access and pulse helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // A missing ack ends the run rather than hanging it
    task automatic xfer(input logic wr, input logic [31:0] a, wd, exp, input logic experr);
        logic [31:0] rd;
        logic        er, ok;
        u_dsr_dbg_model.access(wr, a, wd, rd, er, ok);
        if (!ok) begin
            n_mismatch++;
            wrap_up();
        end else begin
            chk({31'h0, er}, {31'h0, experr});
            if (!wr) chk(rd, exp);
        end
    endtask
    task automatic pulse(input logic [7:0] m);
        @(posedge mclk_i);
        #1 evt = m;
        @(posedge mclk_i);
        #1 evt = 8'h00;
    endtask
    task automatic resets(input logic p);
        @(posedge mclk_i);
        #1 srst_i = 1'b1;
        por_i = p;
        repeat (2) @(posedge mclk_i);
        #1 srst_i = 1'b0;
        por_i = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (20) @(posedge mclk_i);
        #1 srst_i = 1'b0;
        por_i = 1'b0;
        for (int i = 0; i < 5; i++) xfer(0, map[i], 0, 0, 0);
        $display("test reset_values done");
        for (int i = 0; i < 3; i++) xfer(1, map[i], 32'hc35aa53c + i, 0, 0);
        for (int i = 0; i < 3; i++) xfer(0, map[i], 0, 32'hc35aa53c + i, 0);
        xfer(1, DSR_ADDR_CORE_SEL, 32'h0001_0012, 0, 0);
        xfer(0, DSR_ADDR_CORE_SEL, 0, 0, 1);
        chk(hcs, 32'hc35aa53c);
        chk(crs, 32'h0001_0012);
        chk(crd, 32'hc35aa53d);
        chk(emc, 32'hc35aa53e);
        $display("test dcb_map done");
        xfer(0, DSR_ADDR_RSVD_LO, 0, 0, 1);
        xfer(0, DSR_ADDR_RSVD_HI, 0, 0, 1);
        xfer(1, 32'he000ee80, 32'hffffffff, 0, 1);
        xfer(0, 32'he000ed00, 0, 0, 1);
        $display("test reserved done");
        xfer(1, DSR_ADDR_HANDLER, 32'hffffffff, 0, 0);
        xfer(0, DSR_ADDR_HANDLER, 0, DSR_HANDLER_MASK, 0);
        xfer(1, DSR_ADDR_HANDLER, 0, 0, 0);
        xfer(0, DSR_ADDR_HANDLER, 0, 0, 0);
        pulse(8'h40);
        xfer(0, DSR_ADDR_HANDLER, 0, 32'h0000_8000, 0);
        chk({31'h0, pend}, 32'h1);
        pulse(8'h80);
        xfer(0, DSR_ADDR_HANDLER, 0, 0, 0);
        $display("test handler done");
        for (int i = 0; i < 5; i++) begin
            pulse(8'h01 << i);
            xfer(0, DSR_ADDR_FAULT, 0, (32'h2 << i) - 1, 0);
        end
        chk({27'h0, flt}, 32'h1f);
        xfer(1, DSR_ADDR_FAULT, 32'hffff_ffea, 0, 0);
        xfer(0, DSR_ADDR_FAULT, 0, 32'h15, 0);
        xfer(1, DSR_ADDR_FAULT, 0, 0, 0);
        xfer(0, DSR_ADDR_FAULT, 0, 32'h15, 0);
        resets(1'b0);
        xfer(0, DSR_ADDR_FAULT, 0, 32'h15, 0);
        $display("test fault_flags done");
        xfer(1, DSR_ADDR_FAULT, 32'h1f, 0, 0);
        pulse(8'h20);
        chk({31'h0, reenter}, 32'h1);
        xfer(0, DSR_ADDR_FAULT, 0, 32'h1, 0);
        resets(1'b1);
        xfer(0, DSR_ADDR_FAULT, 0, 0, 0);
        $display("test step_and_por done");
        wrap_up();
    end
endmodule // tb_top
